// ---- dv/lvpmc_assertions.sv ----
`timescale 1ns/100ps
module lvpmc_checker (
	// clock and resets
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        por_n,
	// bus
	input wire logic        hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// far side and system
	input wire logic        stop_mode,
	input wire logic        detector_power_on,
	input wire logic        detect_trip_select,
	input wire logic        warning_trip_select,
	input wire logic        powerdown_enable,
	input wire lvpmc_pkg::lvpmc_depth_t powerdown_depth_select,
	input wire logic        undervoltage_irq,
	input wire logic        undervoltage_reset_req
);
	import lvpmc_pkg::*;
	// ****
	// data phase tracking
	// ****
	logic        dp_q;
	logic        wr_q;
	logic        lock_q;
	logic [11:0] a_q;
	wire         wd0 = dp_q && wr_q && a_q == 12'h000;
	wire         wd4 = dp_q && wr_q && a_q == 12'h004;
	wire         rd0 = dp_q && !wr_q && a_q == 12'h000;
	wire         rd4 = dp_q && !wr_q && a_q == 12'h004;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_q   <= 1'h0;
			wr_q   <= 1'h0;
			a_q    <= 12'h000;
			lock_q <= 1'h0;
		end else if (hready) begin
			dp_q   <= hsel && htrans[1];
			wr_q   <= hwrite;
			a_q    <= haddr;
			lock_q <= lock_q || wd4;
		end
	end
	// ****
	// properties
	// ****
	// por also drops hresetn, so one disable covers both domains
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn || !por_n);
	chk_bus_okay:
	assert property (hreadyout && !hresp) else $error("bus not ready");
	chk_rdata_idle:
	assert property (!(dp_q && !wr_q) |-> hrdata == 32'h0000_0000)
	else $error("read data outside data phase");
	chk_det_ackzero:
	assert property (rd0 |-> !hrdata[6] && hrdata[31:8] == 24'h00_0000)
	else $error("detect ack reads one");
	chk_wrn_ackzero:
	assert property (rd4 |-> !hrdata[6] && !hrdata[2])
	else $error("warning acks read one");
	chk_irq_hold:
	assert property (undervoltage_irq && !wd0 |=> undervoltage_irq)
	else $error("detect request dropped");
	chk_reset_gate:
	assert property (undervoltage_reset_req |-> detector_power_on || stop_mode)
	else $error("reset request with detector off");
	chk_once_lock:
	assert property (lock_q |=> $stable(powerdown_enable)
		&& $stable(powerdown_depth_select)) else $error("second write taken");
	chk_trip_hold:
	assert property (!wd4 |=> $stable(detect_trip_select)
		&& $stable(warning_trip_select)) else $error("trip select moved");
	cover property (undervoltage_irq);
	cover property (wd4 && lock_q);
	cover property (stop_mode && detector_power_on);
endmodule

// ---- dv/lvpmc_supply_model.sv ----
`timescale 1ns/100ps
module lvpmc_supply_model
	import lvpmc_pkg::*;
#(
	parameter logic [7:0] DET_LO = 8'h20,
	parameter logic [7:0] DET_HI = 8'h30,
	parameter logic [7:0] WRN_LO = 8'h40,
	parameter logic [7:0] WRN_HI = 8'h50
) (
	// stimulus
	input  wire logic         hclk,
	input  wire logic [7:0]   supply_level,
	input  wire logic         sleep_req,
	// from the block
	input  wire logic         detect_trip_select,
	input  wire logic         warning_trip_select,
	input  wire logic         detector_power_on,
	input  wire logic         powerdown_enable,
	input  wire lvpmc_depth_t powerdown_depth_select,
	// to the block
	output logic              undervoltage_detector,
	output logic              supply_warning,
	output logic              stop_mode,
	output logic              partial_powerdown_exit
);
	// an unpowered comparator reports a healthy supply
	assign undervoltage_detector = detector_power_on
		&& supply_level < (detect_trip_select ? DET_HI : DET_LO);
	assign supply_warning = supply_level
		< (warning_trip_select ? WRN_HI : WRN_LO);
	// ****
	// stop sequencer, one-cycle recovery pulse
	// ****
	always_ff @(posedge hclk) begin
		stop_mode <= sleep_req;
		partial_powerdown_exit <= stop_mode && !sleep_req && powerdown_enable
			&& powerdown_depth_select == LVPMC_PARTIAL_PD;
	end
endmodule

// ---- dv/lvpmc_testbench.sv ----
`timescale 1ns/100ps
`define CHK(g, e) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[FAIL] %0t got %h exp %h", $time, g, e); \
	end \
end
module testbench;
	import lvpmc_pkg::*;
	logic         hclk, hresetn, por_n, hsel, hwrite, hready, hresp, irq;
	logic         sleep_req, undervoltage_detector, supply_warning, stop_mode;
	logic         partial_powerdown_exit, detect_trip_select, rdy;
	logic         warning_trip_select, detector_power_on, powerdown_enable;
	logic         undervoltage_irq, undervoltage_reset_req;
	logic [11:0]  haddr;
	logic [1:0]   htrans;
	logic [31:0]  hwdata, hrdata, rdv;
	logic [7:0]   vlev;
	logic         ce;
	lvpmc_depth_t depth;
	int           num_errors = 0;
	int           n_tests = 0;
	lvpmc_top DUT (.hclk, .hresetn, .por_n, .clk_en(ce), .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
		.hreadyout(hready), .hresp, .undervoltage_detector, .supply_warning,
		.stop_mode, .partial_powerdown_exit, .detect_trip_select,
		.warning_trip_select, .detector_power_on, .powerdown_enable,
		.powerdown_depth_select(depth), .undervoltage_irq,
		.undervoltage_reset_req, .irq);
	lvpmc_supply_model u_model (.hclk, .supply_level(vlev), .sleep_req,
		.detect_trip_select, .warning_trip_select, .detector_power_on,
		.powerdown_enable, .powerdown_depth_select(depth),
		.undervoltage_detector, .supply_warning, .stop_mode,
		.partial_powerdown_exit);
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#900000;
		num_errors++;
		close_out;
	end
	task automatic close_out;
		if (num_errors == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ready and read data are taken at the rising edge that ends the phase
	task automatic wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			rdv = hrdata;
			rdy = hready;
			i++;
		end while (rdy !== 1'h1 && i < 20);
		if (i >= 20) begin
			num_errors++;
			close_out;
		end
	endtask
	task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, d};
		wait_rdy;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(a, 1'h1, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		bus(a, 1'h0, 8'h00);
		`CHK(rdv, {24'h00_0000, e})
	endtask
	task automatic setv(input logic [7:0] v);
		@(posedge hclk);
		vlev <= v;
	endtask
	task automatic nap;
		@(posedge hclk);
		sleep_req <= 1'h1;
		repeat (3) @(posedge hclk);
		sleep_req <= 1'h0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic hrst(input logic p);
		@(posedge hclk);
		hresetn <= 1'h0;
		por_n <= !p;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		por_n <= 1'h1;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_detect;
		rc(12'h000, 8'h1C);
		setv(8'h10);
		rc(12'h000, 8'h9C);
		`CHK(undervoltage_reset_req, 1'h1)
		wr(12'h000, 8'h24);
		@(negedge hclk);
		`CHK({undervoltage_irq, undervoltage_reset_req, irq}, 3'h4)
		setv(8'hFF);
		wr(12'h000, 8'h64);
		rc(12'h000, 8'h24);
		wr(12'h000, 8'h20);
		setv(8'h10);
		rc(12'h000, 8'h20);
	endtask
	task automatic t_stop;
		wr(12'h000, 8'h0C);
		@(posedge hclk);
		sleep_req <= 1'h1;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		`CHK(detector_power_on, 1'h1)
		wr(12'h000, 8'h04);
		@(negedge hclk);
		`CHK(detector_power_on, 1'h0)
		@(posedge hclk);
		sleep_req <= 1'h0;
	endtask
	task automatic t_warn;
		wr(12'h004, 8'h73);
		rc(12'h004, 8'hB3);
		`CHK({powerdown_enable, depth}, 2'h3)
		setv(8'h60);
		wr(12'h004, 8'h40);
		rc(12'h004, 8'h03);
	endtask
	task automatic t_ppd;
		nap;
		rc(12'h004, 8'h0B);
		wr(12'h00C, 8'h04);
		wr(12'h004, 8'h00);
		rc(12'h004, 8'h0B);
		`CHK(irq, 1'h1)
		wr(12'h004, 8'h04);
		rc(12'h004, 8'h03);
		wr(12'h008, 8'h04);
		rc(12'h008, 8'h03);
		`CHK(irq, 1'h0)
	endtask
	task automatic t_reset;
		wr(12'h020, 8'hFF);
		rc(12'h020, 8'h00);
		wr(12'h004, 8'h30);
		hrst(1'h0);
		rc(12'h000, 8'h1C);
		rc(12'h004, 8'h30);
		wr(12'h004, 8'h32);
		nap;
		rc(12'h004, 8'h32);
		hrst(1'h1);
		rc(12'h004, 8'h00);
		@(posedge hclk);
		ce <= 1'h0;
		wr(12'h00C, 8'h07);
		@(posedge hclk);
		ce <= 1'h1;
		rc(12'h00C, 8'h00);
	endtask
	initial begin
		{hresetn, por_n, hsel, hwrite, sleep_req} = 5'h00;
		{haddr, htrans, hwdata} = 46'h0000_0000_0000;
		vlev = 8'hFF;
		ce = 1'h1;
		repeat (16) @(posedge hclk);
		hresetn <= 1'h1;
		por_n <= 1'h1;
		t_detect;
		t_stop;
		t_warn;
		t_ppd;
		t_reset;
		close_out;
	end
endmodule
bind lvpmc_top lvpmc_checker u_chk (.hclk, .hresetn, .por_n, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .stop_mode,
	.detector_power_on, .detect_trip_select, .warning_trip_select,
	.powerdown_enable, .powerdown_depth_select, .undervoltage_irq,
	.undervoltage_reset_req);

// ---- inc/lvpmc_defs.svh ----
`ifndef LVPMC_DEFS_SVH
`define LVPMC_DEFS_SVH

// ********************************
// register byte addresses
// ********************************
`define LVPMC_ADDR_DET_CTRL   12'h000
`define LVPMC_ADDR_WARN_CTRL  12'h004
`define LVPMC_ADDR_IRQ_STATUS 12'h008
`define LVPMC_ADDR_IRQ_MASK   12'h00C
`define LVPMC_ADDR_ENV_STATUS 12'h010

// ********************************
// detect control fields
// ********************************
`define LVPMC_DET_FLAG_BIT    7
`define LVPMC_DET_ACK_BIT     6
`define LVPMC_DET_IRQEN_BIT   5
`define LVPMC_DET_RSTEN_BIT   4
`define LVPMC_DET_STOPEN_BIT  3
`define LVPMC_DET_EN_BIT      2

// ********************************
// warning and power-down fields
// ********************************
`define LVPMC_WRN_FLAG_BIT    7
`define LVPMC_WRN_ACK_BIT     6
`define LVPMC_WRN_DTRIP_BIT   5
`define LVPMC_WRN_WTRIP_BIT   4
`define LVPMC_WRN_PPD_BIT     3
`define LVPMC_WRN_PARTIAL_POWERDOWN_ACK_BIT  2
`define LVPMC_WRN_PDEN_BIT    1
`define LVPMC_WRN_DEPTH_BIT   0

// ********************************
// interrupt status bits
// ********************************
`define LVPMC_IRQ_DET_BIT     0
`define LVPMC_IRQ_WRN_BIT     1
`define LVPMC_IRQ_PPD_BIT     2

// ********************************
// reset values
// ********************************
`define LVPMC_DET_CTRL_RST    8'h1C
`define LVPMC_REG_ZERO        8'h00
`define LVPMC_IRQ_ZERO        3'h0

`endif

// ---- inc/lvpmc_pkg.sv ----
package lvpmc_pkg;

	// ********************************
	// power-down depth
	// ********************************
	typedef enum logic [0:0] {
		LVPMC_FULL_PD    = 1'b0,
		LVPMC_PARTIAL_PD = 1'b1
	} lvpmc_depth_t;

	// ********************************
	// write-once tracking state
	// ********************************
	typedef enum logic [0:0] {
		LVPMC_OPEN   = 1'b0,
		LVPMC_LOCKED = 1'b1
	} lvpmc_once_t;

endpackage

// ---- verilog/lvpmc_sticky_flag.sv ----
`timescale 1ns/100ps
module lvpmc_sticky_flag (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic clk_en,
	// control
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_o <= 1'b0;
		end else if (clk_en) begin
			// set wins so an event on the ack cycle is kept
			if (set_i) begin
				flag_o <= 1'b1;
			end else if (clr_i) begin
				flag_o <= 1'b0;
			end
		end
	end

endmodule

// ---- verilog/lvpmc_top.sv ----
// Contract
// - detect event sets read-only flag bit 7 while detection enabled
// - writing 1 to detect ack bit 6 clears flag; reads 0
// - interrupt enable bit 5 requests interrupt while detect flag set
// - reset enable bit 4 with detection on forces reset on flag
// - stop enable bit 3 keeps detection running during stop mode
// - enable bit 2 turns detection on and gates flag, reset, stop
// - write-once bits accept first write after reset only
// - warning flag bit 7 sets when supply is below warning trip
// - warning ack bit 6 clears flag only if no warning; reads 0
// - bit 5 selects detect trip; cleared only on power-on reset
// - bit 4 selects warning trip; cleared only on power-on reset
// - partial power-down flag bit 3 sets on exit from partial mode
// - writing 1 to ack bit 2 clears partial power-down flag; reads 0
// - write-once bit 1 enables power-down stop modes
// - write-once bit 0 selects full (0) or partial (1) power-down
`timescale 1ns/100ps
`include "lvpmc_defs.svh"
module lvpmc_top (
	// clock, clock enable and resets
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        por_n,
	input  wire logic        clk_en,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// comparators and stop sequencer
	input  wire logic        undervoltage_detector,
	input  wire logic        supply_warning,
	input  wire logic        stop_mode,
	input  wire logic        partial_powerdown_exit,
	output logic             detect_trip_select,
	output logic             warning_trip_select,
	output logic             detector_power_on,
	output logic             powerdown_enable,
	output lvpmc_pkg::lvpmc_depth_t powerdown_depth_select,
	// system outputs
	output logic             undervoltage_irq,
	output logic             undervoltage_reset_req,
	output logic             irq
);
	import lvpmc_pkg::*;

	// ********************************
	// helpers
	// ********************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a[11:2] == r[11:2]);
	endfunction

	// ********************************
	// bus address phase capture
	// ********************************
	logic        wr_q;
	logic        rd_q;
	logic [11:0] addr_q;
	logic        take;
	logic        wr_d;
	logic        bus_rd_d;
	logic [11:0] addr_d;

	// the slave never stalls, so every data phase finishes at once
	assign take      = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ********************************
	// next data phase
	// ********************************
	always_comb begin
		wr_d     = take & hwrite;
		bus_rd_d = take & ~hwrite;
		addr_d   = haddr;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 12'h000;
		end else if (clk_en) begin
			wr_q   <= wr_d;
			rd_q   <= bus_rd_d;
			addr_q <= addr_d;
		end
	end

	logic wr_det;
	logic wr_wrn;
	logic wr_ist;
	logic wr_msk;
	logic [7:0] wd;

	assign wd     = hwdata[7:0];
	assign wr_det = wr_q & hit(addr_q, `LVPMC_ADDR_DET_CTRL);
	assign wr_wrn = wr_q & hit(addr_q, `LVPMC_ADDR_WARN_CTRL);
	assign wr_ist = wr_q & hit(addr_q, `LVPMC_ADDR_IRQ_STATUS);
	assign wr_msk = wr_q & hit(addr_q, `LVPMC_ADDR_IRQ_MASK);

	// ********************************
	// detect control
	// ********************************
	logic det_irqen_q;
	logic det_rsten_q;
	logic det_stopen_q;
	logic det_en_q;
	logic det_irqen_d;
	logic det_rsten_d;
	logic det_stopen_d;
	logic det_en_d;

	localparam logic [7:0] DET_RST = `LVPMC_DET_CTRL_RST;

	// ********************************
	// detect control next value
	// ********************************
	// held unless the detect register is written
	always_comb begin
		det_irqen_d  = det_irqen_q;
		det_rsten_d  = det_rsten_q;
		det_stopen_d = det_stopen_q;
		det_en_d     = det_en_q;
		if (wr_det) begin
			det_irqen_d  = wd[`LVPMC_DET_IRQEN_BIT];
			det_rsten_d  = wd[`LVPMC_DET_RSTEN_BIT];
			det_stopen_d = wd[`LVPMC_DET_STOPEN_BIT];
			det_en_d     = wd[`LVPMC_DET_EN_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_irqen_q  <= DET_RST[`LVPMC_DET_IRQEN_BIT];
			det_rsten_q  <= DET_RST[`LVPMC_DET_RSTEN_BIT];
			det_stopen_q <= DET_RST[`LVPMC_DET_STOPEN_BIT];
			det_en_q     <= DET_RST[`LVPMC_DET_EN_BIT];
		end else if (clk_en) begin
			det_irqen_q  <= det_irqen_d;
			det_rsten_q  <= det_rsten_d;
			det_stopen_q <= det_stopen_d;
			det_en_q     <= det_en_d;
		end
	end

	// detection runs when enabled, and in stop only when stop enable set
	assign detector_power_on = det_en_q & (~stop_mode | det_stopen_q);

	logic det_flag;
	logic det_set;
	logic det_clr;

	assign det_set = detector_power_on & undervoltage_detector;
	assign det_clr = wr_det & wd[`LVPMC_DET_ACK_BIT];

	lvpmc_sticky_flag u_det_flag (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.set_i   (det_set),
		.clr_i   (det_clr),
		.flag_o  (det_flag)
	);

	assign undervoltage_irq = det_flag & det_irqen_q;
	// reset request only while enable bit 2 is set, also in stop with detection off; cleared enable blocks it
	assign undervoltage_reset_req = det_flag & det_rsten_q & det_en_q;

	// ********************************
	// trip selects, kept across non-power-on resets
	// ********************************
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			detect_trip_select  <= 1'b0;
			warning_trip_select <= 1'b0;
		end else if (clk_en && wr_wrn) begin
			detect_trip_select  <= wd[`LVPMC_WRN_DTRIP_BIT];
			warning_trip_select <= wd[`LVPMC_WRN_WTRIP_BIT];
		end
	end

	// ********************************
	// warning flag
	// ********************************
	logic wrn_flag;
	logic wrn_clr;

	// comparator still low keeps the flag, so ack only lands once clear
	assign wrn_clr = wr_wrn & wd[`LVPMC_WRN_ACK_BIT] & ~supply_warning;

	lvpmc_sticky_flag u_wrn_flag (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.set_i   (supply_warning),
		.clr_i   (wrn_clr),
		.flag_o  (wrn_flag)
	);

	// ********************************
	// partial power-down recovery flag
	// ********************************
	logic ppd_flag;
	logic ppd_clr;

	assign ppd_clr = wr_wrn & wd[`LVPMC_WRN_PARTIAL_POWERDOWN_ACK_BIT];

	lvpmc_sticky_flag u_ppd_flag (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.set_i   (partial_powerdown_exit),
		.clr_i   (ppd_clr),
		.flag_o  (ppd_flag)
	);

	// ********************************
	// write-once power-down controls
	// ********************************
	logic [1:0] pd_bits;

	lvpmc_write_once u_pd_once (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clk_en  (clk_en),
		.wr_i    (wr_wrn),
		.data_i  ({wd[`LVPMC_WRN_PDEN_BIT], wd[`LVPMC_WRN_DEPTH_BIT]}),
		.value_o (pd_bits)
	);

	assign powerdown_enable = pd_bits[1];
	// depth only matters when power-down is enabled
	assign powerdown_depth_select = lvpmc_depth_t'(pd_bits[0]);

	// ********************************
	// interrupt status and mask
	// ********************************
	logic [2:0] ist_q;
	logic [2:0] msk_q;
	logic [2:0] ev;
	logic [2:0] ev_prev_q;
	logic [2:0] rise;
	logic [2:0] ist_d;
	logic [2:0] msk_d;
	logic [2:0] ist_clr;

	assign ev   = {ppd_flag, wrn_flag, det_flag};
	assign rise = ev & ~ev_prev_q;

	// ********************************
	// status and mask next value
	// ********************************
	always_comb begin
		ist_clr = 3'h0;
		msk_d   = msk_q;
		if (wr_ist) begin
			ist_clr = wd[2:0];
		end
		if (wr_msk) begin
			msk_d = wd[2:0];
		end
		// set beats write-one-to-clear in the same cycle
		ist_d = rise | (ist_q & ~ist_clr);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_prev_q <= `LVPMC_IRQ_ZERO;
			ist_q     <= `LVPMC_IRQ_ZERO;
		end else if (clk_en) begin
			ev_prev_q <= ev;
			ist_q     <= ist_d;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msk_q <= `LVPMC_IRQ_ZERO;
		end else if (clk_en) begin
			msk_q <= msk_d;
		end
	end

	assign irq = |(ist_q & msk_q);

	// ********************************
	// read mux
	// ********************************
	logic [7:0] det_rd;
	logic [7:0] wrn_rd;
	logic [7:0] rd_d;
	logic [31:0] hrdata_d;

	// ack bits read as zero
	assign det_rd = {det_flag, 1'b0, det_irqen_q, det_rsten_q,
			det_stopen_q, det_en_q, 2'b00};
	assign wrn_rd = {wrn_flag, 1'b0, detect_trip_select,
			warning_trip_select, ppd_flag, 1'b0, pd_bits};

	always_comb begin
		rd_d = `LVPMC_REG_ZERO;
		if (hit(haddr, `LVPMC_ADDR_DET_CTRL)) begin
			rd_d = det_rd;
		end else if (hit(haddr, `LVPMC_ADDR_WARN_CTRL)) begin
			rd_d = wrn_rd;
		end else if (hit(haddr, `LVPMC_ADDR_IRQ_STATUS)) begin
			rd_d = {5'h00, ist_q};
		end else if (hit(haddr, `LVPMC_ADDR_IRQ_MASK)) begin
			rd_d = {5'h00, msk_q};
		end else if (hit(haddr, `LVPMC_ADDR_ENV_STATUS)) begin
			rd_d = {4'h0, stop_mode, detector_power_on,
				supply_warning, undervoltage_detector};
		end
	end

	// ********************************
	// read data register
	// ********************************
	// zero outside a read data phase so a stale word never leaks
	always_comb begin
		hrdata_d = 32'h0000_0000;
		if (bus_rd_d) begin
			hrdata_d = {24'h00_0000, rd_d};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (clk_en) begin
			hrdata <= hrdata_d;
		end
	end

endmodule

// ---- verilog/lvpmc_write_once.sv ----
`timescale 1ns/100ps
module lvpmc_write_once
	import lvpmc_pkg::*;
(
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic clk_en,
	// write port
	input  wire logic wr_i,
	input  wire logic [1:0] data_i,
	output logic [1:0] value_o
);

	lvpmc_once_t state_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= LVPMC_OPEN;
			value_o <= 2'b00;
		end else if (clk_en) begin
			case (state_q)
				LVPMC_OPEN: begin
					if (wr_i) begin
						value_o <= data_i;
						state_q <= LVPMC_LOCKED;
					end
				end
				LVPMC_LOCKED: begin
					state_q <= LVPMC_LOCKED;
				end
				default: begin
					state_q <= LVPMC_LOCKED;
				end
			endcase
		end
	end

endmodule
